// file: src/reload_pwm_pkg.sv
// Package with constants and types for the auto-reload PWM timer.
`default_nettype none
package reload_pwm_pkg;
   localparam int CNT_W = 8;
   localparam int CHANNELS = 4;
   localparam int PRESCALE_W = 7;
   localparam int PR_SEL_W = 3;
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
   // Last count value of a period: a reload of 254 then gives a single step.
   localparam logic [CNT_W-1:0] CNT_TOP = 8'hfe;
   localparam logic [CNT_W-1:0] RELOAD_RESET = 8'h00;
   localparam logic [CNT_W-1:0] DUTY_RESET = 8'hff;
   localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 7'h00;

   typedef enum logic {
      POL_HIGH_BELOW,
      POL_LOW_BELOW
   } polarity_t;

   typedef struct packed {
      logic enable;
      polarity_t polarity;
      logic [CNT_W-1:0] duty_compare_value;
   } channel_cfg_t;

   typedef struct packed {
      logic counter_enable;
      logic use_external_count_clock;
      logic [PR_SEL_W-1:0] prescale_ratio;
      logic timebase_irq_enable;
      logic [CNT_W-1:0] reload_value;
   } timer_cfg_t;

   typedef struct packed {
      logic load;
      logic [CNT_W-1:0] counter_access_value;
   } counter_load_t;
endpackage
`default_nettype wire

// file: src/auto_reload_pwm_timer.sv
// Eight-bit auto-reload timer with prescaler and four PWM compare channels.
`default_nettype none

// Notes on behaviour
// - The counter clock is the input clock divided by 1, 2, 4, 8, 16, 32, 64 or 128.
// - The input clock is the CPU clock unless the external count clock option is selected.
// - In time-base use an interrupt pulse is raised once per reload period.
// - The period is 255 minus the reload value counter steps, from 1 at 254 to 255 at 0.
// - Four PWM pins each have their own polarity and duty compare value.
// - Polarity 0 drives low while the counter exceeds duty and high otherwise; 1 inverts.
// - Resolution follows from the reload value, since the counter spans reload to its top.
// - At each overflow the counter reloads from the reload value and the prescaler clears.
// - A counter access write loads the counter at once and clears the prescaler.
module auto_reload_pwm_timer #(
   parameter int CNT_WIDTH = reload_pwm_pkg::CNT_W
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_external_count_clock,
   input wire reload_pwm_pkg::timer_cfg_t i_cfg,
   input wire reload_pwm_pkg::counter_load_t i_counter_load,
   input wire reload_pwm_pkg::channel_cfg_t [reload_pwm_pkg::CHANNELS-1:0] i_channel,
   output logic [reload_pwm_pkg::CNT_W-1:0] o_counter,
   output logic o_overflow,
   output logic o_timebase_irq,
   output logic o_pulse_out_0,
   output logic o_pulse_out_1,
   output logic o_pulse_out_2,
   output logic o_pulse_out_3
);
   import reload_pwm_pkg::*;

   // External clock passes three flip-flops; the edge is taken from the second and the third.
   logic ext_meta_q, ext_sync_q, ext_prev_q;
   logic ext_edge;

   logic [PRESCALE_W-1:0] prescale_q, prescale_d;
   logic [CNT_W-1:0] counter_q, counter_d;
   logic overflow_q, overflow_d;
   logic irq_q, irq_d;
   logic [CHANNELS-1:0] pulse_q, pulse_d;
   logic input_tick;
   logic count_tick;
   logic tick_due;

   // Returns true when the prescaler has reached the selected ratio.
   function automatic logic ratio_reached(input logic [PRESCALE_W-1:0] cnt,
                                          input logic [PR_SEL_W-1:0] sel);
      logic [PRESCALE_W-1:0] mask;
      mask = PRESCALE_W'((8'h01 << sel) - 8'h01);
      return (cnt & mask) == mask;
   endfunction

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         ext_meta_q <= i_external_count_clock;
         ext_sync_q <= ext_meta_q;
         ext_prev_q <= ext_sync_q;
      end
   end

   assign ext_edge = ext_sync_q & ~ext_prev_q;
   assign input_tick = i_cfg.use_external_count_clock ? ext_edge : 1'b1;
   assign tick_due = ratio_reached(prescale_q, i_cfg.prescale_ratio);
   assign count_tick = i_cfg.counter_enable & input_tick & tick_due;

   always_comb begin
      prescale_d = prescale_q;
      counter_d = counter_q;
      overflow_d = 1'b0;
      irq_d = 1'b0;
      if (i_counter_load.load) begin
         counter_d = i_counter_load.counter_access_value;
         prescale_d = PRESCALE_RESET;
      end else if (i_cfg.counter_enable && input_tick) begin
         if (tick_due) begin
            prescale_d = PRESCALE_RESET;
            // The top count sits one below 0xff, so a period spans 255 minus the reload.
            if (counter_q == CNT_TOP) begin
               counter_d = i_cfg.reload_value;
               overflow_d = 1'b1;
               irq_d = i_cfg.timebase_irq_enable;
            end else begin
               counter_d = counter_q + 8'h01;
            end
         end else begin
            prescale_d = prescale_q + 7'h01;
         end
      end
   end

   // Each channel compares the counter with its duty value; falls out of the range.
   always_comb begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
         pulse_d[ch] = (counter_d <= i_channel[ch].duty_compare_value) ^
                       (i_channel[ch].polarity == POL_LOW_BELOW);
         if (!i_channel[ch].enable) begin
            pulse_d[ch] = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         prescale_q <= PRESCALE_RESET;
         counter_q <= CNT_RESET;
         overflow_q <= 1'b0;
         irq_q <= 1'b0;
         pulse_q <= '0;
      end else begin
         prescale_q <= prescale_d;
         counter_q <= counter_d;
         overflow_q <= overflow_d;
         irq_q <= irq_d;
         pulse_q <= pulse_d;
      end
   end

   assign o_counter = counter_q;
   assign o_overflow = overflow_q;
   assign o_timebase_irq = irq_q;
   assign o_pulse_out_0 = pulse_q[0];
   assign o_pulse_out_1 = pulse_q[1];
   assign o_pulse_out_2 = pulse_q[2];
   assign o_pulse_out_3 = pulse_q[3];

   sequence s_top_tick;
      !i_counter_load.load && count_tick && counter_q == CNT_TOP;
   endsequence

   a_overflow_reload: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_top_tick |=> counter_q == $past(i_cfg.reload_value) && overflow_q)
      else $error("Counter did not reload at overflow.");

   a_count_up_step: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (!i_counter_load.load && count_tick && counter_q != CNT_TOP)
      |=> counter_q == $past(counter_q) + 8'h01)
      else $error("Counter did not step up by one.");

   a_access_load: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_counter_load.load |=> counter_q == $past(i_counter_load.counter_access_value)
      && prescale_q == PRESCALE_RESET)
      else $error("Counter access write not applied.");

   a_hold_no_tick: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (!i_counter_load.load && !count_tick) |=> $stable(counter_q))
      else $error("Counter moved without a tick.");

   a_prescale_div: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (count_tick && !i_counter_load.load) |=> prescale_q == PRESCALE_RESET)
      else $error("Prescaler not cleared on counter tick.");

   a_ext_select: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_cfg.use_external_count_clock && !ext_edge && !i_counter_load.load)
      |=> $stable(counter_q) && $stable(prescale_q))
      else $error("Counted without an external clock edge.");

   a_irq_period: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_timebase_irq |-> o_overflow)
      else $error("Time-base interrupt outside overflow.");

   a_irq_raised: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (s_top_tick and i_cfg.timebase_irq_enable) |=> o_timebase_irq)
      else $error("Time-base interrupt missing.");

   a_pulse_level: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_channel[0].enable && $stable(i_channel[0]) ##1 $stable(i_channel[0])
      |-> o_pulse_out_0 == ((counter_q <= i_channel[0].duty_compare_value)
      ^ (i_channel[0].polarity == POL_LOW_BELOW)))
      else $error("Channel 0 level wrong.");

   // The prescaler advances on each input tick that does not yet reach the ratio.
   sequence s_prescale_wait;
      !i_counter_load.load && i_cfg.counter_enable && input_tick && !tick_due;
   endsequence

   a_prescale_step: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_prescale_wait |=> prescale_q == $past(prescale_q) + 7'h01)
      else $error("Prescaler did not advance on an input tick.");

   // A stopped counter refuses ticks: neither the count nor the prescaler moves.
   a_disabled_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (!i_counter_load.load && !i_cfg.counter_enable)
      |=> $stable(counter_q) && $stable(prescale_q))
      else $error("Stopped counter moved.");

   a_overflow_source: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_overflow |-> $past(count_tick && !i_counter_load.load && counter_q == CNT_TOP))
      else $error("Overflow without a tick at the top count.");

   a_irq_masked: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (s_top_tick and !i_cfg.timebase_irq_enable) |=> !o_timebase_irq)
      else $error("Time-base interrupt while disabled.");

   sequence s_access_write;
      i_counter_load.load;
   endsequence

   a_load_no_overflow: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_access_write |=> !o_overflow && !o_timebase_irq)
      else $error("Overflow raised by a counter access write.");

   // Every channel is checked, the disabled ones included.
   for (genvar g = 0; g < CHANNELS; g++) begin : g_pulse_check
      a_pulse_follow: assert property (@(posedge i_clk) disable iff (!i_nrst)
         i_channel[g].enable |=> pulse_q[g] ==
         ((counter_q <= $past(i_channel[g].duty_compare_value))
         ^ ($past(i_channel[g].polarity) == POL_LOW_BELOW)))
         else $error("Pulse level does not follow the counter.");

      a_pulse_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
         !i_channel[g].enable |=> !pulse_q[g])
         else $error("Disabled pulse pin not low.");
   end
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking testbench for the auto-reload PWM timer.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import reload_pwm_pkg::*;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic ext_clk = 1'b0;
   timer_cfg_t cfg = '0;
   counter_load_t ld = '0;
   channel_cfg_t [CHANNELS-1:0] ch = '0;
   logic [CNT_W-1:0] cnt;
   logic ovf;
   logic irq;
   wire logic [3:0] pulse;
   int n_mismatch = 0;
   int checked = 0;

   auto_reload_pwm_timer i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_external_count_clock(ext_clk),
      .i_cfg(cfg), .i_counter_load(ld), .i_channel(ch), .o_counter(cnt), .o_overflow(ovf),
      .o_timebase_irq(irq), .o_pulse_out_0(pulse[0]), .o_pulse_out_1(pulse[1]),
      .o_pulse_out_2(pulse[2]), .o_pulse_out_3(pulse[3]));

   initial begin
      forever #25 i_clk = ~i_clk;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #5;
   endtask

   task automatic load(input logic [7:0] v);
      ld = '{load: 1'b1, counter_access_value: v};
      tick(1);
      ld.load = 1'b0;
   endtask

   // Each enabled pin follows the compare of the shown counter against its duty value.
   task automatic pins();
      for (int i = 0; i < 4; i++) begin
         check("pulse", ch[i].enable & ((cnt <= ch[i].duty_compare_value) ^ ch[i].polarity),
            pulse[i]);
      end
   endtask

   // Measures the gap between two overflow pulses, checking pins and interrupt each cycle.
   task automatic period(input logic [2:0] ratio, input logic [7:0] rel, input logic irq_en);
      int n;
      cfg = '{1'b1, 1'b0, ratio, irq_en, rel};
      load(CNT_TOP);
      n = 0;
      while (ovf !== 1'b1 && n < 1000) begin
         tick(1);
         n++;
      end
      n = 0;
      do begin
         tick(1);
         n++;
         pins();
         check("irq", ovf & irq_en, irq);
      end while (ovf !== 1'b1 && n < 40000);
      check("period", (255 - rel) << ratio, n);
   endtask

   task automatic load_now();
      int n;
      cfg = '{1'b0, 1'b0, 3'h3, 1'b0, 8'h00};
      load(8'h5a);
      tick(1);
      check("counter", 8'h5a, cnt);
      cfg.counter_enable = 1'b1;
      tick(3);
      load(8'h10);
      n = 0;
      while (cnt !== 8'h10 && n < 4) begin
         tick(1);
         n++;
      end
      n = 0;
      while (cnt === 8'h10 && n < 100) begin
         tick(1);
         n++;
      end
      check("ticks after load", 8, n);
   endtask

   task automatic external();
      cfg = '{1'b1, 1'b1, 3'h0, 1'b0, 8'h00};
      load(8'h10);
      tick(10);
      check("counter", 8'h10, cnt);
      repeat (5) begin
         ext_clk = 1'b1;
         tick(4);
         ext_clk = 1'b0;
         tick(4);
      end
      check("counter", 8'h15, cnt);
   endtask

   // A reset in mid-run clears every output, and nothing counts afterwards without an edge.
   task automatic reset_mid();
      i_nrst = 1'b0;
      tick(2);
      check("counter in reset", 8'h00, cnt);
      check("overflow in reset", 1'b0, ovf);
      check("irq in reset", 1'b0, irq);
      check("pulses in reset", 4'h0, pulse);
      i_nrst = 1'b1;
      tick(2);
      check("counter after reset", 8'h00, cnt);
      pins();
   endtask

   task automatic give_verdict();
      if (n_mismatch == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #(20000 * 50);
      n_mismatch++;
      give_verdict();
   end

   initial begin
      ch[0] = '{1'b1, POL_HIGH_BELOW, 8'hf8};
      ch[1] = '{1'b1, POL_LOW_BELOW, 8'hf0};
      ch[2] = '{1'b1, POL_HIGH_BELOW, 8'h80};
      ch[3] = '{1'b0, POL_LOW_BELOW, 8'hff};
      tick(16);
      check("reset counter", 8'h00, cnt);
      i_nrst = 1'b1;
      tick(2);
      period(3'h0, 8'h00, 1'b1);
      ch[0].duty_compare_value = 8'hff;
      ch[1].duty_compare_value = 8'hff;
      ch[2].duty_compare_value = 8'hff;
      period(3'h0, 8'hfe, 1'b0);
      ch[0].duty_compare_value = 8'hfd;
      ch[1].duty_compare_value = 8'hfd;
      ch[2].duty_compare_value = 8'hfe;
      for (int r = 0; r < 8; r++) begin
         period(r[2:0], 8'hfc, r[0]);
      end
      load_now();
      external();
      reset_mid();
      give_verdict();
   end
endmodule
`default_nettype wire
